/* pkg/dasr_pkg.sv */
// Constants, states and carrier structs for the address and soft-reset register bank.
// Assumes a 100 MHz clk_in and an I2C host that follows the usual start, stop and ack rules.
package dasr_pkg;

  // Register offsets inside the device register space
  localparam logic [7:0] OFF_BUS_ADDRESS_SELECT  = 8'h00;
  localparam logic [7:0] OFF_SOFT_RESET_CONTROL  = 8'h01;

  // Field positions
  localparam int BUS_ADDRESS_FIELD_MSB           = 7;
  localparam int BUS_ADDRESS_FIELD_LSB           = 1;
  localparam int ADDRESS_SOURCE_SELECT_BIT       = 0;
  localparam int FULL_RESET_BIT                  = 1;
  localparam int LOGIC_RESET_BIT                 = 0;

  // Reset values and the read value of unmapped offsets
  localparam logic       ADDRESS_SOURCE_SELECT_RST = 1'b0;
  localparam logic [7:0] SOFT_RESET_CONTROL_RST    = 8'h04;
  localparam logic [7:0] READ_UNMAPPED             = 8'h00;

  // Internal reset pulse width
  localparam int CLK_PERIOD_NS                   = 10;
  localparam int RST_PULSE_NS                    = 80;
  localparam int RST_PULSE_CYC_INT = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] RST_PULSE_CYC           = 4'(RST_PULSE_CYC_INT);

  localparam logic [3:0] BITS_PER_BYTE           = 4'h8;

  typedef enum logic [8:0] {
    ST_IDLE      = 9'h001,
    ST_ADDR      = 9'h002,
    ST_ADDR_ACK  = 9'h004,
    ST_OFFS      = 9'h008,
    ST_OFFS_ACK  = 9'h010,
    ST_WDATA     = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA     = 9'h080,
    ST_RDATA_MACK = 9'h100
  } dasr_state_t;

  typedef struct packed {
    dasr_state_t st;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic [7:0]  ptr;
    logic        rw;
    logic        mack_nack;
    logic        scl_q;
    logic        sda_q;
    logic        sda_oe;
    logic        cap_done;
    logic [6:0]  strap_addr;
    logic [6:0]  bus_addr;
    logic        addr_sel;
    logic [5:0]  res_hi;
    logic [6:0]  act_addr;
  } dasr_regs_t;

  localparam dasr_regs_t REGS_RST = '{
    st: ST_IDLE, cnt: 4'h0, sh: 8'h00, ptr: 8'h00, rw: 1'b0, mack_nack: 1'b0,
    scl_q: 1'b1, sda_q: 1'b1, sda_oe: 1'b0, cap_done: 1'b0, strap_addr: 7'h00,
    bus_addr: 7'h00, addr_sel: ADDRESS_SOURCE_SELECT_RST,
    res_hi: SOFT_RESET_CONTROL_RST[7:2], act_addr: 7'h00};

  typedef struct packed {
    logic       active;
    logic [3:0] cnt;
  } dasr_pulse_t;

  localparam dasr_pulse_t PULSE_RST = '{active: 1'b0, cnt: 4'h0};

endpackage

/* logic/dasr_pulse.sv */
// Self-clearing internal reset pulse of fixed width.
// Assumes start_in is a one-cycle request; requests while active are ignored.
`timescale 1ns/1ps
module dasr_pulse (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic start_in,
  output logic      active_out,
  output logic      done_out
);

  dasr_pkg::dasr_pulse_t q;
  dasr_pkg::dasr_pulse_t d;

  always_comb begin
    d = q;
    if (!q.active && start_in) begin
      d.active = 1'b1;
      d.cnt    = dasr_pkg::RST_PULSE_CYC - 4'h1;
    end else if (q.active) begin
      if (q.cnt == 4'h0) begin
        d.active = 1'b0;  // see R11
      end else begin
        d.cnt = q.cnt - 4'h1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= dasr_pkg::PULSE_RST;
    end else begin
      q <= d;
    end
  end

  assign active_out = q.active;
  assign done_out   = q.active && (q.cnt == 4'h0);

  property p_pulse_width;
    @(posedge clk_in) disable iff (!resetn_in)
      (!q.active && start_in) |=> active_out [*8] ##1 !active_out;
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("reset pulse width wrong"); // see R11

endmodule

/* logic/dasr_regs.sv */
// I2C register slave holding the bus address register and the soft reset register.
// Assumes scl_in and sda_in are already synchronous to clk_in and glitch free.
// Overview of operation
// R1 - Upper seven bits hold strap-loaded bus address
// R2 - Address field writable, reads strap value after reset
// R3 - Bit 0 selects strap or register address
// R4 - Bit 1 write resets everything, self-clears
// R5 - Full reset reloads strap-sampled register values
// R6 - Bit 0 write resets logic, keeps registers
// R7 - Reset register reads 0x04 after reset
// R8 - Address register offset 0, reset register 1
// R9 - Host leaves unlisted offsets untouched
// R10 - Host issues logic reset after output enable
// R11 - Reset bits read zero once pulse ends
`timescale 1ns/1ps
module dasr_regs (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic [6:0] address_strap_pin_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  output logic            full_reset_with_registers_out,
  output logic            logic_reset_keep_registers_out,
  output logic [6:0]      active_address_out
);

  dasr_pkg::dasr_regs_t q;
  dasr_pkg::dasr_regs_t d;

  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic       wr_en;
  logic [7:0] rdata;
  logic       full_start;
  logic       logic_start;
  logic       full_active;
  logic       full_done;
  logic       logic_active;

  assign scl_rise   = !q.scl_q && scl_in;
  assign scl_fall   = q.scl_q && !scl_in;
  assign start_cond = q.scl_q && scl_in && q.sda_q && !sda_in;
  assign stop_cond  = q.scl_q && scl_in && !q.sda_q && sda_in;
  assign wr_en      = scl_fall && (q.st == dasr_pkg::ST_WDATA) && (q.cnt == dasr_pkg::BITS_PER_BYTE);

  // Requests land on the pulse units the cycle the data byte completes
  assign full_start  = wr_en && (q.ptr == dasr_pkg::OFF_SOFT_RESET_CONTROL)
                       && q.sh[dasr_pkg::FULL_RESET_BIT];  // see R4
  assign logic_start = wr_en && (q.ptr == dasr_pkg::OFF_SOFT_RESET_CONTROL)
                       && q.sh[dasr_pkg::LOGIC_RESET_BIT];  // see R6

  // Read data; reset bits show the live pulse state so they self-clear
  always_comb begin
    if (q.ptr == dasr_pkg::OFF_BUS_ADDRESS_SELECT) begin
      rdata = {q.bus_addr, q.addr_sel};  // see R8
    end else if (q.ptr == dasr_pkg::OFF_SOFT_RESET_CONTROL) begin
      rdata = {q.res_hi, full_active, logic_active};  // see R7 R11
    end else begin
      rdata = dasr_pkg::READ_UNMAPPED;
    end
  end

  always_comb begin
    d       = q;
    d.scl_q = scl_in;
    d.sda_q = sda_in;
    // Answer at strap or register address
    d.act_addr = q.addr_sel ? q.bus_addr : q.strap_addr;  // see R3

    if (start_cond) begin
      d.st     = dasr_pkg::ST_ADDR;
      d.cnt    = 4'h0;
      d.sda_oe = 1'b0;
    end else if (stop_cond) begin
      d.st     = dasr_pkg::ST_IDLE;
      d.sda_oe = 1'b0;
    end else if (scl_rise) begin
      if (q.st == dasr_pkg::ST_RDATA_MACK) begin
        d.mack_nack = sda_in;
      end else if (q.st == dasr_pkg::ST_ADDR || q.st == dasr_pkg::ST_OFFS
                   || q.st == dasr_pkg::ST_WDATA) begin
        d.sh  = {q.sh[6:0], sda_in};
        d.cnt = q.cnt + 4'h1;
      end
    end else if (scl_fall) begin
      unique case (q.st)
        dasr_pkg::ST_IDLE: begin
        end
        dasr_pkg::ST_ADDR: begin
          if (q.cnt == dasr_pkg::BITS_PER_BYTE) begin
            if (q.sh[7:1] == q.act_addr) begin  // see R1 R3
              d.st     = dasr_pkg::ST_ADDR_ACK;
              d.rw     = q.sh[0];
              d.sda_oe = 1'b1;
            end else begin
              d.st = dasr_pkg::ST_IDLE;
            end
          end
        end
        dasr_pkg::ST_ADDR_ACK: begin
          d.cnt = 4'h0;
          if (q.rw) begin
            d.st     = dasr_pkg::ST_RDATA;
            d.sh     = rdata;
            d.sda_oe = !rdata[7];
            d.cnt    = 4'h1;
            d.ptr    = q.ptr + 8'h01;
          end else begin
            d.st     = dasr_pkg::ST_OFFS;
            d.sda_oe = 1'b0;
          end
        end
        dasr_pkg::ST_OFFS: begin
          if (q.cnt == dasr_pkg::BITS_PER_BYTE) begin
            d.ptr    = q.sh;
            d.st     = dasr_pkg::ST_OFFS_ACK;
            d.sda_oe = 1'b1;
          end
        end
        dasr_pkg::ST_OFFS_ACK, dasr_pkg::ST_WDATA_ACK: begin
          d.st     = dasr_pkg::ST_WDATA;
          d.cnt    = 4'h0;
          d.sda_oe = 1'b0;
        end
        dasr_pkg::ST_WDATA: begin
          if (q.cnt == dasr_pkg::BITS_PER_BYTE) begin
            // Unmapped offsets accept the byte and drop it
            if (q.ptr == dasr_pkg::OFF_BUS_ADDRESS_SELECT) begin
              d.bus_addr = q.sh[7:1];  // see R2 R8
              d.addr_sel = q.sh[0];
            end else if (q.ptr == dasr_pkg::OFF_SOFT_RESET_CONTROL) begin
              d.res_hi = q.sh[7:2];
            end
            d.ptr    = q.ptr + 8'h01;
            d.st     = dasr_pkg::ST_WDATA_ACK;
            d.sda_oe = 1'b1;
          end
        end
        dasr_pkg::ST_RDATA: begin
          if (q.cnt == dasr_pkg::BITS_PER_BYTE) begin
            d.st     = dasr_pkg::ST_RDATA_MACK;
            d.sda_oe = 1'b0;
          end else begin
            d.sh     = {q.sh[6:0], 1'b0};
            d.sda_oe = !q.sh[6];
            d.cnt    = q.cnt + 4'h1;
          end
        end
        dasr_pkg::ST_RDATA_MACK: begin
          if (q.mack_nack) begin
            d.st = dasr_pkg::ST_IDLE;
          end else begin
            d.st     = dasr_pkg::ST_RDATA;
            d.sh     = rdata;
            d.sda_oe = !rdata[7];
            d.cnt    = 4'h1;
            d.ptr    = q.ptr + 8'h01;
          end
        end
        default: begin
          d.st     = dasr_pkg::ST_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end

    // Strap is caught on the first edge after release, never under the async reset
    if (!q.cap_done) begin
      d.cap_done   = 1'b1;
      d.strap_addr = address_strap_pin_in;  // see R1
      d.bus_addr   = address_strap_pin_in;  // see R2
    end

    // End of full reset: registers return to defaults, strap ones to the caught strap
    if (full_done) begin
      d.bus_addr = q.strap_addr;  // see R5
      d.addr_sel = dasr_pkg::ADDRESS_SOURCE_SELECT_RST;
      d.res_hi   = dasr_pkg::SOFT_RESET_CONTROL_RST[7:2];  // see R4 R7
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= dasr_pkg::REGS_RST;
    end else begin
      q <= d;
    end
  end

  dasr_pulse u_full_pulse (
    .clk_in     (clk_in),
    .resetn_in  (resetn_in),
    .start_in   (full_start),
    .active_out (full_active),
    .done_out   (full_done)
  );

  dasr_pulse u_logic_pulse (
    .clk_in     (clk_in),
    .resetn_in  (resetn_in),
    .start_in   (logic_start),
    .active_out (logic_active),
    .done_out   ()
  );

  // Open drain: only ever pulls low
  assign sda_out                        = 1'b0;
  assign sda_oe_out                     = q.sda_oe;
  assign full_reset_with_registers_out  = full_active;
  assign logic_reset_keep_registers_out = logic_active;
  assign active_address_out             = q.act_addr;

  sequence s_first_edge;
    !q.cap_done;
  endsequence

  sequence s_addr_match;
    scl_fall && !start_cond && !stop_cond && (q.st == dasr_pkg::ST_ADDR)
      && (q.cnt == dasr_pkg::BITS_PER_BYTE) && (q.sh[7:1] == active_address_out);
  endsequence

  property p_strap_load;
    @(posedge clk_in) disable iff (!resetn_in)
      s_first_edge |=> (q.bus_addr == $past(address_strap_pin_in))
                       && (q.strap_addr == $past(address_strap_pin_in));
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("strap not loaded"); // see R1

  property p_rst_value;
    @(posedge clk_in) disable iff (!resetn_in)
      s_first_edge |-> (rdata == dasr_pkg::SOFT_RESET_CONTROL_RST
                        || q.ptr != dasr_pkg::OFF_SOFT_RESET_CONTROL) && !q.addr_sel
                       && (q.res_hi == dasr_pkg::SOFT_RESET_CONTROL_RST[7:2]);
  endproperty
  a_rst_value: assert property (p_rst_value) else $error("reset register value wrong"); // see R7

  property p_ack_address;
    @(posedge clk_in) disable iff (!resetn_in)
      s_addr_match |=> (q.st == dasr_pkg::ST_ADDR_ACK) && sda_oe_out;
  endproperty
  a_ack_address: assert property (p_ack_address) else $error("own address not acked"); // see R3

  property p_addr_source;
    @(posedge clk_in) disable iff (!resetn_in)
      (q.cap_done && !q.addr_sel) ##1 q.cap_done |-> active_address_out == $past(q.strap_addr);
  endproperty
  a_addr_source: assert property (p_addr_source) else $error("strap address not used"); // see R3

  property p_addr_write;
    @(posedge clk_in) disable iff (!resetn_in)
      (wr_en && q.cap_done && !full_done && q.ptr == dasr_pkg::OFF_BUS_ADDRESS_SELECT)
        |=> (q.bus_addr == $past(q.sh[7:1])) && (q.addr_sel == $past(q.sh[0]));
  endproperty
  a_addr_write: assert property (p_addr_write) else $error("address register write lost"); // see R2 R8

  property p_full_pulse;
    @(posedge clk_in) disable iff (!resetn_in)
      (full_start && !full_active) |=> full_reset_with_registers_out [*8]
                                       ##1 !full_reset_with_registers_out;
  endproperty
  a_full_pulse: assert property (p_full_pulse) else $error("full reset pulse wrong"); // see R4

  property p_full_reload;
    @(posedge clk_in) disable iff (!resetn_in)
      full_done |=> (q.bus_addr == q.strap_addr) && !q.addr_sel
                    && (q.res_hi == dasr_pkg::SOFT_RESET_CONTROL_RST[7:2]);
  endproperty
  a_full_reload: assert property (p_full_reload) else $error("strap reload missed"); // see R5

  property p_logic_pulse;
    @(posedge clk_in) disable iff (!resetn_in)
      (logic_start && !logic_active && !full_active && q.cap_done)
        |=> logic_reset_keep_registers_out [*8] ##1 !logic_reset_keep_registers_out;
  endproperty
  a_logic_pulse: assert property (p_logic_pulse) else $error("logic reset pulse wrong"); // see R6

  property p_self_clear;
    @(posedge clk_in) disable iff (!resetn_in)
      full_done |=> !full_reset_with_registers_out
                    && (!rdata[dasr_pkg::FULL_RESET_BIT]
                        || q.ptr != dasr_pkg::OFF_SOFT_RESET_CONTROL);
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("reset bit not cleared"); // see R11

endmodule

/* verif/dasr_host.sv */
// I2C host model that reaches the register bank over scl and sda.
// Assumes the testbench resolves the sda wire with a pull-up from all enables.
`timescale 1ns/1ps
module dasr_host (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  initial begin
    scl_out    = 1'b1;
    sda_oe_out = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Works from idle and as a repeated start, since sda is released first
  task automatic start_cond();
    sda_oe_out = 1'b0;
    hold(2);
    scl_out = 1'b1;
    hold(4);
    sda_oe_out = 1'b1;
    hold(4);
    scl_out = 1'b0;
    hold(2);
  endtask

  task automatic stop_cond();
    sda_oe_out = 1'b1;
    hold(2);
    scl_out = 1'b1;
    hold(4);
    sda_oe_out = 1'b0;
    hold(4);
  endtask

  // Each scl phase lasts 4 cycles; sda moves mid-low and is sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    sda_oe_out = ~b;
    hold(2);
    scl_out = 1'b1;
    hold(2);
    r = sda_in;
    hold(2);
    scl_out = 1'b0;
    hold(2);
  endtask

  task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                         output logic ack_seen);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(ack_in, r);
    ack_seen = ~r;
  endtask

  task automatic write_reg(input logic [6:0] addr, input logic [7:0] off,
                           input logic [7:0] data, output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    start_cond();
    byte_io({addr, 1'b0}, 1'b1, rx, a0);
    byte_io(off, 1'b1, rx, a1);
    byte_io(data, 1'b1, rx, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask

  // The read always ends with a host NACK so the device lets go of sda
  task automatic read_reg(input logic [6:0] addr, input logic [7:0] off,
                          output logic [7:0] data, output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       na;
    start_cond();
    byte_io({addr, 1'b0}, 1'b1, rx, a0);
    byte_io(off, 1'b1, rx, a1);
    start_cond();
    byte_io({addr, 1'b1}, 1'b1, rx, a2);
    byte_io(8'hFF, 1'b1, data, na);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask

  // Two-byte read: the host acks the first byte so the pointer moves on by itself
  task automatic read_pair(input logic [6:0] addr, input logic [7:0] off,
                           output logic [7:0] d0, output logic [7:0] d1, output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       na;
    start_cond();
    byte_io({addr, 1'b0}, 1'b1, rx, a0);
    byte_io(off, 1'b1, rx, a1);
    start_cond();
    byte_io({addr, 1'b1}, 1'b1, rx, a2);
    byte_io(8'hFF, 1'b0, d0, na);
    byte_io(8'hFF, 1'b1, d1, na);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
endmodule

/* verif/device_address_and_soft_reset_tb.sv */
// Self-checking testbench for the address and soft-reset register bank.
// Assumes the I2C host model drives scl and its sda enable on falling clock edges.
`timescale 1ns/1ps
module device_address_and_soft_reset_tb;
  logic       clk_in;
  logic       resetn_in;
  logic       scl;
  logic       host_oe;
  logic       sda;
  logic       sda_out;
  logic       sda_oe_out;
  logic       full_rst;
  logic       keep_rst;
  logic [6:0] strap;
  logic [6:0] active;
  logic [7:0] rd;
  logic [7:0] rd2;
  logic       ok;
  int         fail_count;
  int         compares;
  int         full_cnt;
  int         full_len;
  int         keep_cnt;
  int         keep_len;

  assign sda = ~host_oe & ~(sda_oe_out & ~sda_out);

  dasr_regs dasr_regs_i (
    .clk_in                         (clk_in),
    .resetn_in                      (resetn_in),
    .scl_in                         (scl),
    .sda_in                         (sda),
    .address_strap_pin_in           (strap),
    .sda_out                        (sda_out),
    .sda_oe_out                     (sda_oe_out),
    .full_reset_with_registers_out  (full_rst),
    .logic_reset_keep_registers_out (keep_rst),
    .active_address_out             (active)
  );

  dasr_host dasr_host_i (
    .clk_in     (clk_in),
    .sda_in     (sda),
    .scl_out    (scl),
    .sda_oe_out (host_oe)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Measures the length of each reset pulse as it ends
  always @(posedge clk_in) begin
    if (full_rst === 1'b1) begin
      full_cnt <= full_cnt + 1;
    end else if (full_cnt != 0) begin
      full_len <= full_cnt;
      full_cnt <= 0;
    end
    if (keep_rst === 1'b1) begin
      keep_cnt <= keep_cnt + 1;
    end else if (keep_cnt != 0) begin
      keep_len <= keep_cnt;
      keep_cnt <= 0;
    end
  end

  task automatic complete_run();
    if (fail_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] off, input logic [7:0] d,
                    input logic exp_ok);
    dasr_host_i.write_reg(a, off, d, ok);
    check("write ack", {7'h00, exp_ok}, {7'h00, ok});
  endtask

  task automatic rd_chk(input string what, input logic [6:0] a, input logic [7:0] off,
                        input logic [7:0] exp);
    dasr_host_i.read_reg(a, off, rd, ok);
    check("read ack", 8'h01, {7'h00, ok});
    check(what, exp, rd);
  endtask

  initial begin
    repeat (50000) @(posedge clk_in);
    fail_count++;
    $display("unexpected run length: expected end within 50000 cycles, seen none");
    complete_run();
  end

  initial begin
    fail_count = 0;
    compares   = 0;
    full_cnt   = 0;
    full_len   = 0;
    keep_cnt   = 0;
    keep_len   = 0;
    resetn_in  = 1'b0;
    strap      = 7'h2C;
    repeat (10) @(negedge clk_in);
    resetn_in = 1'b1;
    repeat (5) @(negedge clk_in);
    // Pin moves after capture; only the sample taken at start-up may count
    strap = 7'h15;
    check("active address", 8'h2C, {1'b0, active});
    rd_chk("address reg", 7'h2C, 8'h00, 8'h58);
    rd_chk("reset reg", 7'h2C, 8'h01, 8'h04);
    rd_chk("unmapped reg", 7'h2C, 8'h23, 8'h00);
    dasr_host_i.read_pair(7'h2C, 8'h00, rd, rd2, ok);
    check("pair ack", 8'h01, {7'h00, ok});
    check("pair address reg", 8'h58, rd);
    check("pair reset reg", 8'h04, rd2);
    wr(7'h2C, 8'h00, 8'h66, 1'b1);
    check("active address", 8'h2C, {1'b0, active});
    rd_chk("address reg", 7'h2C, 8'h00, 8'h66);
    wr(7'h2C, 8'h00, 8'h67, 1'b1);
    check("active address", 8'h33, {1'b0, active});
    wr(7'h2C, 8'h00, 8'h00, 1'b0);
    wr(7'h33, 8'h01, 8'h1C, 1'b1);
    rd_chk("reset reg", 7'h33, 8'h01, 8'h1C);
    wr(7'h33, 8'h01, 8'h1D, 1'b1);
    check("keep pulse", {4'h0, dasr_pkg::RST_PULSE_CYC}, 8'(keep_len));
    check("full pulse", 8'h00, 8'(full_len));
    rd_chk("reset reg", 7'h33, 8'h01, 8'h1C);
    rd_chk("address reg", 7'h33, 8'h00, 8'h67);
    wr(7'h33, 8'h01, 8'h1E, 1'b1);
    check("full pulse", {4'h0, dasr_pkg::RST_PULSE_CYC}, 8'(full_len));
    check("active address", 8'h2C, {1'b0, active});
    rd_chk("address reg", 7'h2C, 8'h00, 8'h58);
    rd_chk("reset reg", 7'h2C, 8'h01, 8'h04);
    // A second hard reset must catch the pin as it stands now
    resetn_in = 1'b0;
    repeat (3) @(negedge clk_in);
    resetn_in = 1'b1;
    repeat (5) @(negedge clk_in);
    check("active address", 8'h15, {1'b0, active});
    rd_chk("address reg", 7'h15, 8'h00, 8'h2A);
    complete_run();
  end
endmodule
